// [design/tdcq_evt_if.sv]
// Carrier between the qualifier register bank and its match logic
`timescale 1ns/1ps
`default_nettype none
interface tdcq_evt_if;
   import tdcq_pkg::*;
   logic [31:0]             qual;
   logic                    evt_valid;
   logic [TDCQ_NCAUSE-1:0]  evt_cause;
   logic [TDCQ_NCLASS-1:0]  evt_class;
   logic [TDCQ_PORT_W-1:0]  evt_port;
   logic                    count_inc;

   modport ctl (output qual, output evt_valid, output evt_cause, output evt_class,
                output evt_port, input count_inc);
   modport mat (input qual, input evt_valid, input evt_cause, input evt_class,
                input evt_port, output count_inc);
endinterface : tdcq_evt_if
`default_nettype wire

// [design/tdcq_match.sv]
// Match logic deciding whether one discarded cell is counted
`timescale 1ns/1ps
`default_nettype none
module tdcq_match
   import tdcq_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // Qualifier and discard event
   tdcq_evt_if.mat   evt
);

   logic [TDCQ_NCAUSE-1:0] cause_sel;
   logic [TDCQ_NCAUSE-1:0] cause_ok;
   logic [TDCQ_NCLASS-1:0] class_sel;
   logic                   pair_sel;
   logic                   port_all;
   logic                   port_hit;
   logic                   cause_hit;
   logic                   class_hit;
   logic                   enabled;
   logic                   nxt_inc;
   logic                   inc_ff;

   assign pair_sel = evt.qual[TDCQ_CAUSE_POS[TDCQ_PICK2_IDX]]
                   | evt.qual[TDCQ_CAUSE_POS[TDCQ_PICK6_IDX]];
   assign port_all = (evt.qual[TDCQ_PORT_LSB +: TDCQ_PORT_W] == TDCQ_PORT_ALL);
   assign port_hit = port_all | (evt.qual[TDCQ_PORT_LSB +: TDCQ_PORT_W] == evt.evt_port);

   genvar i;
   generate
      for (i = 0; i < TDCQ_NCAUSE; i++) begin : g_cause
         if (i == TDCQ_PICK2_IDX || i == TDCQ_PICK6_IDX) begin : g_pair
            assign cause_sel[i] = pair_sel;
         end else begin : g_single
            assign cause_sel[i] = evt.qual[TDCQ_CAUSE_POS[i]];
         end
         if (i >= TDCQ_NCAUSE - TDCQ_NGLOB) begin : g_glob
            assign cause_ok[i] = cause_sel[i] & port_all;
         end else begin : g_local
            assign cause_ok[i] = cause_sel[i];
         end
      end
      for (i = 0; i < TDCQ_NCLASS; i++) begin : g_class
         assign class_sel[i] = evt.qual[TDCQ_CLASS_POS[i]];
      end
   endgenerate

   assign cause_hit = |(evt.evt_cause & cause_ok);
   assign class_hit = |(evt.evt_class & class_sel);
   // enable bit gates, wipe bit ignored
   assign enabled   = evt.qual[TDCQ_ENABLE_POS];
   assign nxt_inc   = evt.evt_valid & enabled & cause_hit & class_hit & port_hit;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         inc_ff <= 1'b0;
      end else begin
         inc_ff <= nxt_inc;
      end
   end

   assign evt.count_inc = inc_ff;

endmodule : tdcq_match
`default_nettype wire

// [design/tdcq_pkg.sv]
// Constants for the threshold discard count qualifier block
//
// Notes on behaviour
// - A set cause select bit makes discards for that threshold cause count; a clear bit excludes it unless its limit_pick_2/limit_pick_6 partner is set.
// - The limit_pick_2 and limit_pick_6 selects act together; either one enables both causes.
// - A set class select bit makes discards of that traffic class count; a clear bit excludes it.
// - With the enable bit at 0 nothing is counted, whatever the wipe bit holds.
// - Enable 1 with wipe 0 counts qualifying discards and leaves the tally alone.
// - Enable 1 with wipe 1 counts qualifying discards.
// - Port filter 00h to 1Dh limits counting to output port 0 to 29; 1Eh must not be programmed.
// - Port filter 1Fh counts qualifying discards on every output port.
// - The four global causes limit_pick_8 to limit_pick_11 count only while the filter is 1Fh.
// - A discard counts only when cause, class and port all match and counting is enabled.
// - The running count sits in a separate read-only tally register, not in the qualifier.
`default_nettype none
package tdcq_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0]  TDCQ_QUAL_OFFS  = 8'h20;
   localparam logic [7:0]  TDCQ_TALLY_OFFS = 8'h40;
   localparam logic [31:0] TDCQ_QUAL_RST   = 32'h0000_0000;
   localparam logic [31:0] TDCQ_QUAL_MASK  = 32'hfe8b_5fdf;
   localparam logic [31:0] TDCQ_TALLY_RST  = 32'h0000_0000;

   // ****************************************
   // Qualifier field layout
   // ****************************************
   localparam int TDCQ_NCAUSE = 11;
   localparam int TDCQ_NCLASS = 6;
   localparam int TDCQ_NGLOB  = 4;
   // limit_pick_1 .. limit_pick_11
   localparam int TDCQ_CAUSE_POS [TDCQ_NCAUSE] = '{31, 30, 29, 28, 27, 26, 25, 23, 19, 17, 16};
   // grade_pick_1 .. grade_pick_6
   localparam int TDCQ_CLASS_POS [TDCQ_NCLASS] = '{14, 12, 11, 10, 9, 8};
   localparam int TDCQ_PICK2_IDX = 1;
   localparam int TDCQ_PICK6_IDX = 5;
   localparam int TDCQ_ENABLE_POS = 7;
   localparam int TDCQ_WIPE_POS   = 6;
   localparam int TDCQ_PORT_LSB   = 0;
   localparam int TDCQ_PORT_W     = 5;
   localparam logic [4:0] TDCQ_PORT_ALL = 5'h1f;

   // ****************************************
   // AXI responses
   // ****************************************
   localparam logic [1:0] TDCQ_RESP_OKAY   = 2'h0;
   localparam logic [1:0] TDCQ_RESP_SLVERR = 2'h2;

endpackage : tdcq_pkg
`default_nettype wire

// [design/tdcq_top.sv]
// Qualifier register bank with AXI4-Lite slave and discard tally
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module tdcq_top
   import tdcq_pkg::*;
#(
   parameter int TALLY_W = 32
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   // AXI4-Lite write address
   input  wire logic [7:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   // Threshold discard event, same clock
   input  wire logic                   disc_valid,
   input  wire logic [TDCQ_NCAUSE-1:0] disc_cause,
   input  wire logic [TDCQ_NCLASS-1:0] disc_class,
   input  wire logic [TDCQ_PORT_W-1:0] disc_port
);

   // ****************************************
   // State
   // ****************************************
   logic [31:0]        qual_ff;
   logic [TALLY_W-1:0] tally_ff;
   logic               aw_held_ff;
   logic               w_held_ff;
   logic [7:0]         awaddr_ff;
   logic [31:0]        wdata_ff;
   logic [3:0]         wstrb_ff;
   logic               awready_ff;
   logic               wready_ff;
   logic               bvalid_ff;
   logic [1:0]         bresp_ff;
   logic               arready_ff;
   logic               rvalid_ff;
   logic [31:0]        rdata_ff;
   logic [1:0]         rresp_ff;

   tdcq_evt_if evt ();

   assign evt.qual      = qual_ff;
   assign evt.evt_valid = disc_valid;
   assign evt.evt_cause = disc_cause;
   assign evt.evt_class = disc_class;
   assign evt.evt_port  = disc_port;

   tdcq_match u_match (
      .clk     (clk),
      .sys_rst (sys_rst),
      .evt     (evt)
   );

   // ****************************************
   // Write path
   // ****************************************
   logic        aw_take;
   logic        w_take;
   logic        do_write;
   logic        wr_qual;
   logic        wr_hit;
   logic [31:0] strb_mask;
   logic [31:0] nxt_qual;
   logic        nxt_aw_held;
   logic        nxt_w_held;
   logic        nxt_bvalid;
   logic        wipe_req;

   assign aw_take     = s_axi_awvalid & awready_ff;
   assign w_take      = s_axi_wvalid & wready_ff;
   assign do_write    = aw_held_ff & w_held_ff & ~bvalid_ff;
   assign wr_qual     = do_write & (awaddr_ff[7:2] == TDCQ_QUAL_OFFS[7:2]);
   // Tally is read-only, so a write to it is refused
   assign wr_hit      = wr_qual;
   assign strb_mask   = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
   assign nxt_qual    = wr_qual
                      ? (((qual_ff & ~strb_mask) | (wdata_ff & strb_mask)) & TDCQ_QUAL_MASK)
                      : qual_ff;
   assign nxt_aw_held = (aw_held_ff | aw_take) & ~do_write;
   assign nxt_w_held  = (w_held_ff | w_take) & ~do_write;
   assign nxt_bvalid  = do_write | (bvalid_ff & ~s_axi_bready);
   // wipe only on a 0 to 11 transition of enable/wipe
   assign wipe_req    = wr_qual & ~qual_ff[TDCQ_ENABLE_POS]
                      & nxt_qual[TDCQ_ENABLE_POS] & nxt_qual[TDCQ_WIPE_POS];

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         aw_held_ff <= 1'b0;
         w_held_ff  <= 1'b0;
         awaddr_ff  <= 8'h00;
         wdata_ff   <= 32'h0000_0000;
         wstrb_ff   <= 4'h0;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= TDCQ_RESP_OKAY;
         qual_ff    <= TDCQ_QUAL_RST;
      end else begin
         aw_held_ff <= nxt_aw_held;
         w_held_ff  <= nxt_w_held;
         awaddr_ff  <= aw_take ? s_axi_awaddr : awaddr_ff;
         wdata_ff   <= w_take ? s_axi_wdata : wdata_ff;
         wstrb_ff   <= w_take ? s_axi_wstrb : wstrb_ff;
         awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
         wready_ff  <= ~nxt_w_held & ~nxt_bvalid;
         bvalid_ff  <= nxt_bvalid;
         bresp_ff   <= do_write ? (wr_hit ? TDCQ_RESP_OKAY : TDCQ_RESP_SLVERR) : bresp_ff;
         qual_ff    <= nxt_qual;
      end
   end

   // ****************************************
   // Discard tally
   // ****************************************
   logic [TALLY_W-1:0] nxt_tally;

   // separate tally, wipe takes priority over a same-cycle count
   assign nxt_tally = wipe_req ? TDCQ_TALLY_RST[TALLY_W-1:0]
                    : (evt.count_inc ? tally_ff + TALLY_W'(1) : tally_ff);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tally_ff <= TDCQ_TALLY_RST[TALLY_W-1:0];
      end else begin
         tally_ff <= nxt_tally;
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   logic        ar_take;
   logic        rd_qual;
   logic        rd_tally;
   logic [31:0] rd_word;
   logic        nxt_rvalid;

   assign ar_take    = s_axi_arvalid & arready_ff;
   assign rd_qual    = (s_axi_araddr[7:2] == TDCQ_QUAL_OFFS[7:2]);
   assign rd_tally   = (s_axi_araddr[7:2] == TDCQ_TALLY_OFFS[7:2]);
   assign rd_word    = rd_qual ? qual_ff
                     : (rd_tally ? 32'(tally_ff) : 32'h0000_0000);
   assign nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= TDCQ_RESP_OKAY;
      end else begin
         arready_ff <= ~nxt_rvalid;
         rvalid_ff  <= nxt_rvalid;
         rdata_ff   <= ar_take ? rd_word : rdata_ff;
         rresp_ff   <= ar_take ? ((rd_qual | rd_tally) ? TDCQ_RESP_OKAY : TDCQ_RESP_SLVERR)
                               : rresp_ff;
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

endmodule : tdcq_top
`default_nettype wire

// [verif/tdcq_props.sv]
// Bus checks on the qualifier block ports
`timescale 1ns/1ps
`default_nettype none
module tdcq_props
   import tdcq_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        sys_rst,
   // Register bus
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire ar_hs = s_axi_arvalid && s_axi_arready;
   property p_ar_ans; ar_hs |=> s_axi_rvalid; endproperty
   a_ar_ans: assert property (p_ar_ans) else $error("read not answered");
   property p_ar_blk; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_blk: assert property (p_ar_blk) else $error("read taken while pending");
   property p_aw_blk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_aw_blk: assert property (p_aw_blk) else $error("write taken while pending");
   property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_r_done: assert property (p_r_done) else $error("read data held too long");
   property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_b_done: assert property (p_b_done) else $error("write response held too long");
   property p_qual_rd; ar_hs && s_axi_araddr == TDCQ_QUAL_OFFS |=>
      s_axi_rresp == TDCQ_RESP_OKAY && (s_axi_rdata & ~TDCQ_QUAL_MASK) == 32'h0; endproperty
   a_qual_rd: assert property (p_qual_rd) else $error("qualifier read wrong");
   property p_bad_rd; ar_hs && s_axi_araddr == 8'h44 |=>
      s_axi_rresp == TDCQ_RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
   a_bad_rd: assert property (p_bad_rd) else $error("unmapped read wrong");
   property p_tally_ro; s_axi_awvalid && s_axi_awready && s_axi_awaddr == TDCQ_TALLY_OFFS
      |-> ##[1:8] s_axi_bvalid && s_axi_bresp == TDCQ_RESP_SLVERR; endproperty
   a_tally_ro: assert property (p_tally_ro) else $error("tally write accepted");
   c_rd: cover property (ar_hs);
   c_err: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == TDCQ_RESP_SLVERR);
   c_ok: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == TDCQ_RESP_OKAY);
endmodule : tdcq_props
bind tdcq_top tdcq_props u_props (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// [verif/threshold_discard_count_qualifier_tb.sv]
// Self-checking bench for the qualifier register and discard tally
`timescale 1ns/1ps
`default_nettype none
module threshold_discard_count_qualifier_tb
   import tdcq_pkg::*;
;
   logic clk = 1'h0, sys_rst = 1'h1;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, mq = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, disc_valid = 1'h0;
   logic [10:0] disc_cause = 11'h0;
   logic [5:0] disc_class = 6'h0;
   logic [4:0] disc_port = 5'h0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   int n_mismatch = 0, check_count = 0, tally = 0;

   always #2.5 clk = ~clk;

   tdcq_top dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .disc_valid, .disc_cause, .disc_class, .disc_port);

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
         n_mismatch++;
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit aw = 0, w = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!(aw && w)) begin
         @(posedge clk);
         if (!aw && s_axi_awready) begin
            aw = 1;
            s_axi_awvalid <= 1'h0;
         end
         if (!w && s_axi_wready) begin
            w = 1;
            s_axi_wvalid <= 1'h0;
         end
      end
      do @(posedge clk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge clk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask : rd

   // Qualifier write with model update
   task automatic wq(input logic [31:0] d);
      logic [1:0] r;
      wr(TDCQ_QUAL_OFFS, d, r);
      chk("qual bresp", 32'(r), 32'(TDCQ_RESP_OKAY));
      if (!mq[TDCQ_ENABLE_POS] && d[TDCQ_ENABLE_POS] && d[TDCQ_WIPE_POS]) tally = 0;
      mq = d & TDCQ_QUAL_MASK;
   endtask : wq

   function automatic bit hit(logic [10:0] c, logic [5:0] k, logic [4:0] p);
      bit ch = 0, kh = 0;
      bit all = mq[4:0] == TDCQ_PORT_ALL;
      for (int i = 0; i < TDCQ_NCAUSE; i++)
         if (c[i] && (mq[TDCQ_CAUSE_POS[i]] || ((i == 1 || i == 5) && (mq[TDCQ_CAUSE_POS[1]]
             || mq[TDCQ_CAUSE_POS[5]]))) && (i < TDCQ_NCAUSE - TDCQ_NGLOB || all)) ch = 1;
      for (int j = 0; j < TDCQ_NCLASS; j++) if (k[j] && mq[TDCQ_CLASS_POS[j]]) kh = 1;
      return mq[TDCQ_ENABLE_POS] && ch && kh && (all || mq[4:0] == p);
   endfunction : hit

   task automatic burst(input int n);
      logic [10:0] c;
      logic [5:0] k;
      logic [4:0] p;
      for (int e = 0; e < n; e++) begin
         c = 11'h1 << ($urandom % 11);
         k = 6'h1 << ($urandom % 6);
         p = ($urandom % 2) ? mq[4:0] : 5'($urandom % 30);
         @(posedge clk);
         disc_valid <= 1'h1;
         disc_cause <= c;
         disc_class <= k;
         disc_port <= p;
         tally += int'(hit(c, k, p));
      end
      @(posedge clk);
      disc_valid <= 1'h0;
      repeat (3) @(posedge clk);
   endtask : burst

   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      complete_run;
   end

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      void'($urandom(50585));
      repeat (8) @(posedge clk);
      sys_rst <= 1'h0;
      repeat (2) @(posedge clk);
      rd(TDCQ_QUAL_OFFS, d, r);
      chk("qual reset", d, TDCQ_QUAL_RST);
      rd(TDCQ_TALLY_OFFS, d, r);
      chk("tally reset", d, TDCQ_TALLY_RST);
      wq(32'hffff_ffff);
      rd(TDCQ_QUAL_OFFS, d, r);
      chk("qual mask", d, TDCQ_QUAL_MASK);
      rd(8'h44, d, r);
      chk("bad rd resp", 32'(r), 32'(TDCQ_RESP_SLVERR));
      chk("bad rd data", d, 32'h0);
      wr(TDCQ_TALLY_OFFS, 32'h5, r);
      chk("tally wr resp", 32'(r), 32'(TDCQ_RESP_SLVERR));
      $display("test registers done");
      repeat (40) begin
         d = $urandom | $urandom;
         d[4:0] = ($urandom % 3) ? 5'($urandom % 30) : TDCQ_PORT_ALL;
         d[TDCQ_ENABLE_POS] = ($urandom % 4) != 0;
         wq(d);
         burst(12);
         rd(TDCQ_TALLY_OFFS, d, r);
         chk("tally", d, 32'(tally));
      end
      $display("test counting done");
      wq(32'hfe8b_5f9f);
      burst(10);
      wq(32'hfe8b_5f1f);
      burst(6);
      rd(TDCQ_TALLY_OFFS, d, r);
      chk("tally disabled", d, 32'(tally));
      wq(32'hfe8b_5fdf);
      rd(TDCQ_TALLY_OFFS, d, r);
      chk("tally wiped", d, 32'h0);
      burst(10);
      rd(TDCQ_TALLY_OFFS, d, r);
      chk("tally after wipe", d, 32'(tally));
      chk("tally rresp", 32'(r), 32'(TDCQ_RESP_OKAY));
      $display("test wipe done");
      complete_run;
   end
endmodule : threshold_discard_count_qualifier_tb
`default_nettype wire
